// ==== src/i2c_bc_defs.vh ====
// Constants for the I2C master arbitration and bus-collision block.
// Assumes one 20 MHz clock and a plain register port with 4 address bits.
`ifndef I2C_BC_DEFS_VH
`define I2C_BC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_XFER_BUF   4'h0
`define OFS_RELOAD     4'h1
`define OFS_CTRL_ONE   4'h2
`define OFS_CTRL_TWO   4'h3
`define OFS_STATUS     4'h4
`define OFS_IRQ_FLAGS  4'h5
`define OFS_IRQ_ENABLE 4'h6

// ****************************************
// Field positions
// ****************************************
`define B1_WRITE_COLLISION_FLAG   7
`define B1_EN     5
`define B2_ACKSTAT 6
`define B2_ACKDT  5
`define B2_ACK_SEQUENCE_REQUEST  4
`define B2_PEN    2
`define B2_RESTART_REQUEST   1
`define B2_SEN    0
`define BS_STOP   4
`define BS_START  3
`define BS_BF     0
`define BI_PORT   0
`define BI_BCOL   1

// ****************************************
// Reset values and fixed levels
// ****************************************
`define RST_BYTE   8'h00
`define RST_RELOAD 8'h13
`define PIN_LOW    1'b0
`define PH_ZERO    3'd0
`define BIT_LAST   4'd8
`define BIT_FIRST  4'd0

`endif

// ==== src/i2c_master_bus_collision.v ====
// I2C master sequencer with multi-master arbitration and collision checks.
// Assumes sda_in/scl_in already synchronous to ref_clk; pins are open drain.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "i2c_bc_defs.vh"

module i2c_master_bus_collision #(
    parameter ADDR_W = 4
) (
    // Clock and reset
    input  wire              ref_clk,
    input  wire              rst_n,
    // Register port
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [7:0]        reg_rdata,
    // Bus pins, open drain
    input  wire              sda_in,
    output wire              sda_out,
    output wire              sda_oe,
    input  wire              scl_in,
    output wire              scl_out,
    output wire              scl_oe,
    // Sleep and slave events
    input  wire              sleep_mode,
    input  wire              slave_addr_match,
    input  wire              slave_byte_done,
    // Requests to the core
    output wire              irq_request,
    output wire              wake_request
);

    // ****************************************
    // State encoding
    // ****************************************
    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_STRT = 6'b000010;
    localparam [5:0] ST_RSTR = 6'b000100;
    localparam [5:0] ST_STOP = 6'b001000;
    localparam [5:0] ST_ACK  = 6'b010000;
    localparam [5:0] ST_TX   = 6'b100000;

    // ****************************************
    // Storage
    // ****************************************
    reg [5:0] state;
    reg [2:0] phase;
    reg [7:0] reload_counter;
    reg [7:0] rate_reload_value;
    reg [7:0] transfer_buffer;
    reg [7:0] shift;
    reg [3:0] bit_cnt;
    reg       sda_low;
    reg       scl_low;
    reg       port_enable_bit;
    reg       write_collision_flag;
    reg       buffer_full_flag;
    reg       start_request;
    reg       restart_request;
    reg       stop_request;
    reg       ack_sequence_request;
    reg       ack_data;
    reg       ack_status;
    reg       start_seen;
    reg       stop_seen;
    reg       port_irq_flag;
    reg       bus_collision_flag;
    reg       port_irq_enable;
    reg       bus_collision_irq_enable;
    reg       sda_prev;
    reg       scl_prev;

    wire cnt_zero = (reload_counter == `RST_BYTE);
    wire busy     = (state != ST_IDLE);
    wire wr_buf   = reg_wr && (reg_addr == `OFS_XFER_BUF);
    wire wr_ctl1  = reg_wr && (reg_addr == `OFS_CTRL_ONE);
    wire wr_ctl2  = reg_wr && (reg_addr == `OFS_CTRL_TWO);
    wire wr_flag  = reg_wr && (reg_addr == `OFS_IRQ_FLAGS);
    wire rd_buf   = reg_rd && (reg_addr == `OFS_XFER_BUF);
    wire stop_det  = scl_in && scl_prev && !sda_prev && sda_in;
    wire start_det = scl_in && scl_prev && sda_prev && !sda_in;

    // Collision decode for the running sequence
    reg  collide;
    reg  done;
    always @* begin
        collide = 1'b0;
        case (state)
            ST_STRT: begin
                if (phase == `PH_ZERO)
                    collide = !sda_in || !scl_in;
                else if (phase == 3'd1)
                    collide = sda_in && !scl_in;
                else
                    collide = 1'b0;
            end
            ST_RSTR: begin
                if (phase == 3'd1)
                    collide = scl_in && !sda_in;
                else if (phase == 3'd2)
                    collide = !scl_in && sda_in;
                else
                    collide = 1'b0;
            end
            ST_STOP: begin
                if (phase == 3'd3)
                    collide = !scl_in;
                else if (phase == 3'd4)
                    collide = cnt_zero && !sda_in;
                else
                    collide = 1'b0;
            end
            ST_ACK:
                collide = (phase == 3'd2) && !sda_low && !sda_in && scl_in;
            ST_TX:
                collide = (phase == 3'd2) && !sda_low && !sda_in && scl_in &&
                          (bit_cnt != `BIT_LAST);
            default:
                collide = 1'b0;
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state                <= ST_IDLE;
            phase                <= `PH_ZERO;
            reload_counter       <= `RST_BYTE;
            shift                <= `RST_BYTE;
            bit_cnt              <= `BIT_FIRST;
            sda_low              <= 1'b0;
            scl_low              <= 1'b0;
            start_request        <= 1'b0;
            restart_request      <= 1'b0;
            stop_request         <= 1'b0;
            ack_sequence_request <= 1'b0;
            ack_status           <= 1'b0;
            buffer_full_flag     <= 1'b0;
            done                 <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!cnt_zero)
                reload_counter <= reload_counter - 8'h01;
            if (rd_buf)
                buffer_full_flag <= 1'b0;
            if (!port_enable_bit) begin
                state                <= ST_IDLE;
                sda_low              <= 1'b0;
                scl_low              <= 1'b0;
                start_request        <= 1'b0;
                restart_request      <= 1'b0;
                stop_request         <= 1'b0;
                ack_sequence_request <= 1'b0;
            end else if (collide) begin
                state                <= ST_IDLE;
                sda_low              <= 1'b0;
                scl_low              <= 1'b0;
                buffer_full_flag     <= 1'b0;
                bit_cnt              <= `BIT_FIRST;
                start_request        <= 1'b0;
                restart_request      <= 1'b0;
                stop_request         <= 1'b0;
                ack_sequence_request <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        phase <= `PH_ZERO;
                        if (wr_buf) begin
                            // Fresh byte always starts at its first bit
                            shift            <= reg_wdata;
                            bit_cnt          <= `BIT_FIRST;
                            buffer_full_flag <= 1'b1;
                            state            <= ST_TX;
                        end else if (start_request)
                            state <= ST_STRT;
                        else if (restart_request)
                            state <= ST_RSTR;
                        else if (stop_request)
                            state <= ST_STOP;
                        else if (ack_sequence_request)
                            state <= ST_ACK;
                        else
                            state <= ST_IDLE;
                    end
                    ST_STRT: begin
                        case (phase)
                            3'd0: begin
                                reload_counter <= rate_reload_value;
                                phase          <= 3'd1;
                            end
                            3'd1: begin
                                if (!sda_in || cnt_zero) begin
                                    sda_low        <= 1'b1;
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd2;
                                end
                            end
                            default: begin
                                if (cnt_zero) begin
                                    scl_low       <= 1'b1;
                                    start_request <= 1'b0;
                                    done          <= 1'b1;
                                    state         <= ST_IDLE;
                                end
                            end
                        endcase
                    end
                    ST_RSTR: begin
                        case (phase)
                            3'd0: begin
                                sda_low        <= 1'b0;
                                reload_counter <= rate_reload_value;
                                phase          <= 3'd4;
                            end
                            3'd4: begin
                                if (cnt_zero) begin
                                    scl_low <= 1'b0;
                                    phase   <= 3'd1;
                                end
                            end
                            3'd1: begin
                                if (scl_in) begin
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd2;
                                end
                            end
                            3'd2: begin
                                if (!sda_in || cnt_zero) begin
                                    sda_low        <= 1'b1;
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd3;
                                end
                            end
                            default: begin
                                if (cnt_zero) begin
                                    scl_low         <= 1'b1;
                                    restart_request <= 1'b0;
                                    done            <= 1'b1;
                                    state           <= ST_IDLE;
                                end
                            end
                        endcase
                    end
                    ST_STOP: begin
                        case (phase)
                            3'd0: begin
                                sda_low <= 1'b1;
                                if (!sda_in) begin
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd1;
                                end
                            end
                            3'd1: begin
                                if (cnt_zero) begin
                                    scl_low <= 1'b0;
                                    phase   <= 3'd2;
                                end
                            end
                            3'd2: begin
                                // Waiting here is clock stretching, not loss
                                if (scl_in) begin
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd3;
                                end
                            end
                            3'd3: begin
                                if (cnt_zero) begin
                                    sda_low        <= 1'b0;
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd4;
                                end
                            end
                            default: begin
                                if (cnt_zero) begin
                                    stop_request <= 1'b0;
                                    done         <= 1'b1;
                                    state        <= ST_IDLE;
                                end
                            end
                        endcase
                    end
                    ST_ACK, ST_TX: begin
                        case (phase)
                            3'd0: begin
                                scl_low        <= 1'b1;
                                reload_counter <= rate_reload_value;
                                if (state == ST_ACK)
                                    sda_low <= !ack_data;
                                else if (bit_cnt == `BIT_LAST)
                                    sda_low <= 1'b0;
                                else
                                    sda_low <= !shift[7];
                                phase <= 3'd1;
                            end
                            3'd1: begin
                                if (cnt_zero) begin
                                    scl_low <= 1'b0;
                                    phase   <= 3'd3;
                                end
                            end
                            3'd3: begin
                                if (scl_in) begin
                                    reload_counter <= rate_reload_value;
                                    phase          <= 3'd2;
                                end
                            end
                            default: begin
                                if (cnt_zero) begin
                                    scl_low <= 1'b1;
                                    phase   <= `PH_ZERO;
                                    if (state == ST_ACK) begin
                                        ack_sequence_request <= 1'b0;
                                        done                 <= 1'b1;
                                        state                <= ST_IDLE;
                                    end else if (bit_cnt == `BIT_LAST) begin
                                        ack_status       <= sda_in;
                                        sda_low          <= 1'b0;
                                        buffer_full_flag <= 1'b0;
                                        bit_cnt          <= `BIT_FIRST;
                                        done             <= 1'b1;
                                        state            <= ST_IDLE;
                                    end else begin
                                        shift   <= {shift[6:0], 1'b0};
                                        bit_cnt <= bit_cnt + 4'd1;
                                    end
                                end
                            end
                        endcase
                    end
                    default:
                        state <= ST_IDLE;
                endcase
                if (wr_ctl2 && !busy) begin
                    start_request        <= reg_wdata[`B2_SEN];
                    restart_request      <= reg_wdata[`B2_RESTART_REQUEST];
                    stop_request         <= reg_wdata[`B2_PEN];
                    ack_sequence_request <= reg_wdata[`B2_ACK_SEQUENCE_REQUEST];
                end
            end
        end
    end

    // ****************************************
    // Software registers and bus watch
    // ****************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_reload_value        <= `RST_RELOAD;
            transfer_buffer          <= `RST_BYTE;
            port_enable_bit          <= 1'b0;
            write_collision_flag     <= 1'b0;
            ack_data                 <= 1'b0;
            start_seen               <= 1'b0;
            stop_seen                <= 1'b0;
            port_irq_flag            <= 1'b0;
            bus_collision_flag       <= 1'b0;
            port_irq_enable          <= 1'b0;
            bus_collision_irq_enable <= 1'b0;
            sda_prev                 <= 1'b1;
            scl_prev                 <= 1'b1;
            reg_rdata                <= `RST_BYTE;
        end else begin
            sda_prev <= sda_in;
            scl_prev <= scl_in;
            if (reg_wr && reg_addr == `OFS_RELOAD)
                rate_reload_value <= reg_wdata;
            if (wr_buf && !busy && port_enable_bit)
                transfer_buffer <= reg_wdata;
            if (wr_ctl2)
                ack_data <= reg_wdata[`B2_ACKDT];
            if (wr_ctl1)
                port_enable_bit <= reg_wdata[`B1_EN];
            // Hardware set wins over a software clear in the same cycle
            write_collision_flag <= (wr_ctl1 ? reg_wdata[`B1_WRITE_COLLISION_FLAG] : write_collision_flag)
                                    | (wr_buf && busy);
            if (reg_wr && reg_addr == `OFS_IRQ_ENABLE) begin
                port_irq_enable          <= reg_wdata[`BI_PORT];
                bus_collision_irq_enable <= reg_wdata[`BI_BCOL];
            end
            bus_collision_flag <= (wr_flag ? reg_wdata[`BI_BCOL] : bus_collision_flag)
                                  | (collide && port_enable_bit);
            port_irq_flag <= (wr_flag ? reg_wdata[`BI_PORT] : port_irq_flag)
                             | done | (stop_det && port_enable_bit);
            if (!port_enable_bit) begin
                start_seen <= 1'b0;
                stop_seen  <= 1'b0;
            end else if (start_det) begin
                start_seen <= 1'b1;
                stop_seen  <= 1'b0;
            end else if (stop_det) begin
                start_seen <= 1'b0;
                stop_seen  <= 1'b1;
            end
            case (reg_addr)
                `OFS_XFER_BUF:   reg_rdata <= transfer_buffer;
                `OFS_RELOAD:     reg_rdata <= rate_reload_value;
                `OFS_CTRL_ONE:   reg_rdata <= {write_collision_flag, 1'b0,
                                               port_enable_bit, 5'd0};
                `OFS_CTRL_TWO:   reg_rdata <= {1'b0, ack_status, ack_data,
                                               ack_sequence_request, 1'b0, stop_request,
                                               restart_request, start_request};
                `OFS_STATUS:     reg_rdata <= {3'd0, stop_seen, start_seen, 2'd0,
                                               buffer_full_flag};
                `OFS_IRQ_FLAGS:  reg_rdata <= {6'd0, bus_collision_flag, port_irq_flag};
                `OFS_IRQ_ENABLE: reg_rdata <= {6'd0, bus_collision_irq_enable,
                                               port_irq_enable};
                default:         reg_rdata <= `RST_BYTE;
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sda_out = `PIN_LOW;
    assign scl_out = `PIN_LOW;
    assign sda_oe  = sda_low;
    assign scl_oe  = scl_low;
    assign irq_request = (port_irq_flag && port_irq_enable) ||
                         (bus_collision_flag && bus_collision_irq_enable);
    // Slave receive logic lives elsewhere; only its wake path is here
    assign wake_request = sleep_mode && port_irq_enable && port_enable_bit &&
                          (slave_addr_match || slave_byte_done);

endmodule // i2c_master_bus_collision

// ==== tb/i2c_bus_partner.sv ====
// Partner: another master and its slaves on the shared open-drain bus.
// Assumes pull-ups on both lines; the bench commands every misbehaviour.
`timescale 1ns/10ps
module i2c_bus_partner (
    input  wire logic sda_oe, scl_oe, hold_sda, hold_scl, collide,
    output wire logic sda, scl
);
    // Pull-ups: a released line reads high, never a stale value
    assign scl = !(scl_oe || hold_scl);
    assign sda = !(sda_oe || hold_sda || (collide && scl));
endmodule // i2c_bus_partner

// ==== tb/i2c_master_bus_collision_checker.sv ====
// Checker: port-level assertions for the bus-collision master.
// Assumes the top module's port names; bound after the module.
`timescale 1ns/10ps
module i2c_master_bus_collision_checker #(parameter ADDR_W = 4) (
    input wire logic              ref_clk, rst_n, reg_wr, reg_rd, sda_in, sda_out, sda_oe,
    input wire logic              scl_in, scl_out, scl_oe, sleep_mode, slave_addr_match,
    input wire logic              slave_byte_done, irq_request, wake_request,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata, reg_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    reset_idle_a: assert property (
        $rose(rst_n) |-> !sda_oe && !scl_oe && !irq_request)
        else $error("lines or request active after reset");
    wake_cause_a: assert property (
        wake_request |-> sleep_mode && (slave_addr_match || slave_byte_done))
        else $error("wake without a slave event in sleep");
    start_refused_a: assert property (
        reg_wr && reg_addr == 3 && reg_wdata[0] && !sda_oe && !scl_oe && !scl_in
        |=> (!sda_oe && !scl_oe)[*3])
        else $error("start driven with a low line");
    reload_back_a: assert property (
        reg_wr && reg_addr == 1 ##2 reg_rd && reg_addr == 1
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("reload value not kept");
    off_clear_a: assert property (
        reg_wr && reg_addr == 2 && !reg_wdata[5] ##2 reg_rd && reg_addr == 4
        |=> reg_rdata[4:3] == 2'b00)
        else $error("start or stop seen while disabled");
    stop_write_collision_flag_a: assert property (
        reg_wr && reg_addr == 3 && reg_wdata[2] ##2 reg_wr && reg_addr == 0
        ##2 reg_rd && reg_addr == 2 |=> reg_rdata[7])
        else $error("no write collision during stop");
    mask_irq_a: assert property (
        reg_wr && reg_addr == 6 && reg_wdata[1:0] == 2'b00 |=> !irq_request)
        else $error("request with enables off");
    open_drain_a: assert property (sda_out == 1'b0 && scl_out == 1'b0)
        else $error("line driven high");
endmodule // i2c_master_bus_collision_checker
bind i2c_master_bus_collision i2c_master_bus_collision_checker #(.ADDR_W(ADDR_W))
    i2c_master_bus_collision_checker_i (.ref_clk, .rst_n, .reg_wr, .reg_rd, .sda_in,
    .sda_out, .sda_oe, .scl_in, .scl_out, .scl_oe, .sleep_mode, .slave_addr_match,
    .slave_byte_done, .irq_request, .wake_request, .reg_addr, .reg_wdata, .reg_rdata);

// ==== tb/i2c_master_bus_collision_bench.sv ====
// Bench: registers, start and transmit collisions, bus stop, sleep wake, reset.
// Assumes the partner model on the pins and the checker bound to the design.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
module i2c_master_bus_collision_bench;
    logic        ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sleep_mode = 0, collide = 0;
    logic        slave_addr_match = 0, slave_byte_done = 0, hold_sda = 0, hold_scl = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, d;
    wire         sda, scl, sda_oe, scl_oe, irq_request, wake_request;
    int          n_mismatch = 0, checked = 0, i;
    // Address, write data, expected read; reload 3 is least legal
    logic [19:0] rows [5] = '{20'h1_0303, 20'h6_0000, 20'h7_ff00, 20'h2_2020, 20'h6_0303};
    i2c_master_bus_collision i2c_master_bus_collision_i (.ref_clk, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sda_in(sda), .sda_out(), .sda_oe,
        .scl_in(scl), .scl_out(), .scl_oe, .sleep_mode, .slave_addr_match,
        .slave_byte_done, .irq_request, .wake_request);
    i2c_bus_partner i2c_bus_partner_i (.sda_oe, .scl_oe, .hold_sda, .hold_scl, .collide,
        .sda, .scl);
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
        @(posedge ref_clk); reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk); reg_rd <= 1; reg_addr <= a;
        @(posedge ref_clk); reg_rd <= 0; #1 d = reg_rdata;
    endtask
    task automatic wait_irq;
        for (i = 0; i < 400 && irq_request !== 1'b1; i++) @(posedge ref_clk);
        `CHK("irq_request", 1'b1, irq_request)
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #25 ref_clk = ~ref_clk;
    initial begin
        #400000 n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        for (int k = 0; k < 5; k++) begin
            wr(rows[k][19:16], rows[k][15:8]); rd(rows[k][19:16]);
            `CHK("register", rows[k][7:0], d)
        end
        $display("test registers done");
        hold_scl <= 1; wr(3, 8'h01); wait_irq; rd(5);
        `CHK("bus_collision_flag", 1'b1, d[1])
        rd(3);
        `CHK("start_request", 1'b0, d[0])
        wr(5, 8'h00); hold_scl <= 0; hold_sda <= 1; repeat (4) @(posedge ref_clk);
        hold_sda <= 0; wait_irq; rd(4);
        `CHK("stop_seen", 1'b1, d[4])
        rd(5);
        `CHK("port_irq_flag", 1'b1, d[0])
        wr(5, 8'h00); wr(3, 8'h01);
        for (i = 0; i < 400 && scl_oe !== 1'b1; i++) @(posedge ref_clk);
        `CHK("start_done", 1'b1, scl_oe)
        $display("test start collision and bus stop done");
        wr(5, 8'h00); collide <= 1; wr(0, 8'h40); wait_irq; rd(4);
        `CHK("buffer_full_flag", 1'b0, d[0])
        `CHK("lines_released", 2'b00, {sda_oe, scl_oe})
        collide <= 0; repeat (4) @(posedge ref_clk); wr(5, 8'h00);
        // Zero in the top bit must pull data low on the first bit cell
        wr(0, 8'h00); repeat (2) @(posedge ref_clk); #1
        `CHK("first_bit_low", 1'b1, sda_oe)
        wait_irq; wr(5, 8'h00); wr(3, 8'h04); wr(0, 8'h55); rd(2);
        `CHK("write_collision_flag", 1'b1, d[7])
        rd(0);
        `CHK("transfer_buffer", 8'h00, d)
        wait_irq; wr(2, 8'h00); rd(4);
        `CHK("start_stop_seen", 2'b00, d[4:3])
        $display("test transmit collision done");
        wr(2, 8'h20); wr(5, 8'h00); hold_sda <= 1; wr(3, 8'h02); wait_irq; rd(5);
        `CHK("restart_collision", 1'b1, d[1])
        rd(3);
        `CHK("restart_request", 1'b0, d[1])
        wr(5, 8'h00); wr(3, 8'h30); wait_irq; rd(5);
        `CHK("ack_collision", 1'b1, d[1])
        rd(3);
        `CHK("ack_sequence_request", 1'b0, d[4])
        hold_sda <= 0;
        $display("test restart and acknowledge collision done");
        sleep_mode <= 1; @(posedge ref_clk); slave_addr_match <= 1; #1
        `CHK("wake_on_match", 1'b1, wake_request)
        @(posedge ref_clk); slave_addr_match <= 0; slave_byte_done <= 1; #1
        `CHK("wake_on_byte", 1'b1, wake_request)
        @(posedge ref_clk); rst_n <= 0; slave_byte_done <= 0; sleep_mode <= 0; #1
        `CHK("reset_lines", 3'b000, {sda_oe, scl_oe, irq_request})
        repeat (3) @(posedge ref_clk); rst_n <= 1; rd(1);
        `CHK("reload_reset", 8'h13, d)
        $display("test sleep and reset done");
        report_and_stop;
    end
endmodule // i2c_master_bus_collision_bench
